// File: pkg/pmd_pkg.sv
// Purpose: Shared constants and types for the peripheral module disable bank.
// Assumes: Classic Wishbone slave, 32-bit data, word register indexes.
// Notes: Byte address of a register is four times its index.
package pmd_pkg;

  localparam int unsigned PMD_NREG = 8;
  localparam int unsigned PMD_AW = 14;

  // Register indexes; the control 0 index sits just below control 1.
  localparam logic [11:0] PMD_IDX_CTRL0 = 12'h796;
  localparam logic [11:0] PMD_IDX_CTRL1 = 12'h797;
  localparam logic [11:0] PMD_IDX_CTRL2 = 12'h798;
  localparam logic [11:0] PMD_IDX_CTRL3 = 12'h799;
  localparam logic [11:0] PMD_IDX_CTRL4 = 12'h79a;
  localparam logic [11:0] PMD_IDX_CTRL5 = 12'h79b;
  localparam logic [11:0] PMD_IDX_CTRL6 = 12'h79c;
  localparam logic [11:0] PMD_IDX_CTRL7 = 12'h79d;

  // Bits that hold state in each register; all others read zero.
  localparam logic [7:0] PMD_MASK0 = 8'hc7;
  localparam logic [7:0] PMD_MASK1 = 8'h7f;
  localparam logic [7:0] PMD_MASK2 = 8'h80;
  localparam logic [7:0] PMD_MASK3 = 8'h67;
  localparam logic [7:0] PMD_MASK4 = 8'h6f;
  localparam logic [7:0] PMD_MASK5 = 8'h60;
  localparam logic [7:0] PMD_MASK6 = 8'h11;
  localparam logic [7:0] PMD_MASK7 = 8'h3f;
  localparam logic [7:0] PMD_RESET = 8'h00;

  // Field positions in control 0.
  localparam int unsigned PMD_B_CLKGATE = 7;
  localparam int unsigned PMD_B_FVR = 6;
  localparam int unsigned PMD_B_NVM = 2;
  localparam int unsigned PMD_B_CLKREF = 1;
  localparam int unsigned PMD_B_IOC = 0;

  // Memory re-enable settle time, ns, and its cycle count at 200 MHz.
  localparam int unsigned PMD_CLK_PERIOD_NS = 5;
  localparam int unsigned PMD_NVM_SETTLE_NS = 1000;
  localparam int unsigned PMD_NVM_SETTLE_CYC = PMD_NVM_SETTLE_NS / PMD_CLK_PERIOD_NS;
  localparam int unsigned PMD_REEN_HOLD_CYC = 2;

  typedef struct packed {
    logic [PMD_AW-1:0] adr;
    logic we;
    logic [3:0] sel;
    logic [31:0] dat;
  } pmd_wb_req_t;

  typedef struct packed {
    logic timer_6_off;
    logic timer_5_off;
    logic timer_4_off;
    logic timer_3_off;
    logic timer_2_off;
    logic timer_1_off;
    logic timer_0_off;
    logic num_osc_off;
    logic dac_off;
    logic adc_off;
    logic comparator2_off;
    logic comparator1_off;
    logic zero_cross_off;
    logic pwm_unit7_off;
    logic pwm_unit6_off;
    logic capcomp4_off;
    logic capcomp3_off;
    logic capcomp2_off;
    logic capcomp1_off;
    logic waveform_gen2_off;
    logic waveform_gen1_off;
    logic async_serial_off;
    logic sync_serial_off;
    logic signal_meas_timer_off;
    logic logic_cell_4_off;
    logic logic_cell_3_off;
    logic logic_cell_2_off;
    logic logic_cell_1_off;
    logic signal_modulator_off;
  } pmd_periph_off_t;

  typedef enum logic [2:0] {
    PMD_NVM_ON = 3'b001,
    PMD_NVM_OFF = 3'b010,
    PMD_NVM_SETTLE = 3'b100
  } pmd_nvm_state_t;

endpackage

// File: hw/pmd_ctrl_reg.sv
// Purpose: One 8-bit disable register with a fixed mask of live bits.
// Assumes: Write strobe and data come from the bus slave on the same clock.
// Notes: Masked bits are never stored, so they read as zero.
`timescale 1ns/1ps
module pmd_ctrl_reg
  import pmd_pkg::*;
#(
  parameter logic [7:0] MASK = 8'hff
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // Write port
  input wire logic wr_in,
  input wire logic [7:0] data_in,
  // Stored value and a pulse per bit that clears this cycle
  output logic [7:0] value_out,
  output logic [7:0] cleared_out
);

  logic [7:0] val_q;
  logic [7:0] val_d;

  assign val_d = wr_in ? (data_in & MASK) : val_q; // [RL19]
  assign value_out = val_q;
  assign cleared_out = val_q & ~val_d;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      val_q <= PMD_RESET; // [RL15]
    end else begin
      val_q <= val_d;
    end
  end

endmodule

// File: hw/pmd_reen_hold.sv
// Purpose: Stretch a re-enable event into a short access hold window.
// Assumes: Event pulse is synchronous to the system clock.
// Notes: A new event restarts the window.
`timescale 1ns/1ps
module pmd_reen_hold
  import pmd_pkg::*;
#(
  parameter int unsigned CYCLES = 2
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // Event and window
  input wire logic start_in,
  output logic busy_out
);

  logic [9:0] cnt_q;
  logic [9:0] cnt_d;

  assign cnt_d = start_in ? 10'(CYCLES) : ((cnt_q != 10'h000) ? cnt_q - 10'h001 : cnt_q);
  assign busy_out = (cnt_q != 10'h000);

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q <= 10'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// File: hw/pmd_bank.sv
// Purpose: Peripheral module disable bank behind a classic Wishbone slave.
// Assumes: 200 MHz system clock, asynchronous active-low reset.
// Notes: Every disable and gate output is registered.
//
// Functional notes
// [RL1] Clock-gate bit stops peripheral clock network.
// [RL2] Control 0 bit 6 disables voltage reference.
// [RL3] Memory-off blocks memory access and controller writes.
// [RL4] Memory-off makes pointer reads of memory zero.
// [RL5] Software waits 1 us after memory re-enable.
// [RL6] Control 0 bit 1 disables reference clock out.
// [RL7] Control 0 bit 0 disables pin-change logic.
// [RL8] Control 1 bits 0-6 disable timers 0-6.
// [RL9] Control 2 bit 7 disables numeric oscillator.
// [RL10] Control 3 disables DAC, ADC, comparators, zero-cross.
// [RL11] Control 4 disables PWM 7, 6, capture 4-1.
// [RL12] Control 5 disables waveform generators 2 and 1.
// [RL13] Control 6 disables async and sync serial.
// [RL14] Control 7 disables measure timer, cells, modulator.
// [RL15] System reset clears all disable bits.
// [RL16] Disabled peripheral held reset, outputs off, unreachable.
// [RL17] Re-enabled peripheral restarts from reset values.
// [RL18] Software avoids re-enabled registers two cycles.
// [RL19] Unused control bits read zero, ignore writes.
`timescale 1ns/1ps
module pmd_bank
  import pmd_pkg::*;
(
  // Clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [PMD_AW-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic wb_err_out,
  // Control 0 outputs
  output logic periph_clock_gate_out,
  output logic voltage_ref_off_out,
  output logic memory_ctrl_off_out,
  output logic ref_clock_out_off_out,
  output logic pin_change_off_out,
  // Memory path gating
  output logic memory_access_block_out,
  output logic memory_ctrl_regs_wr_block_out,
  output logic indirect_pointer_zero_out,
  output logic memory_settling_out,
  // Peripheral disables, each held in reset while set
  output pmd_periph_off_t periph_off_out,
  // Per-register hold windows after any bit of it re-enables a peripheral
  output logic [PMD_NREG-1:0] reen_busy_out
);

  // Bus decode.
  pmd_wb_req_t req;
  logic [11:0] idx;
  logic access;
  logic [PMD_NREG-1:0] hit;
  logic mapped;
  logic wr_en;
  logic ack_q;
  logic err_q;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic [7:0] rsel;

  assign req = '{adr: wb_adr_in, we: wb_we_in, sel: wb_sel_in, dat: wb_dat_in};
  assign idx = req.adr[PMD_AW-1:2];
  assign access = wb_cyc_in && wb_stb_in && !ack_q && !err_q;

  assign hit[0] = (idx == PMD_IDX_CTRL0);
  assign hit[1] = (idx == PMD_IDX_CTRL1);
  assign hit[2] = (idx == PMD_IDX_CTRL2);
  assign hit[3] = (idx == PMD_IDX_CTRL3);
  assign hit[4] = (idx == PMD_IDX_CTRL4);
  assign hit[5] = (idx == PMD_IDX_CTRL5);
  assign hit[6] = (idx == PMD_IDX_CTRL6);
  assign hit[7] = (idx == PMD_IDX_CTRL7);
  assign mapped = |hit;
  // Only byte lane 0 carries register data; other lanes are ignored.
  assign wr_en = access && mapped && req.we && req.sel[0];

  localparam logic [7:0] MASKS [PMD_NREG] = '{PMD_MASK0, PMD_MASK1, PMD_MASK2,
    PMD_MASK3, PMD_MASK4, PMD_MASK5, PMD_MASK6, PMD_MASK7};

  logic [7:0] regv [PMD_NREG];
  logic [7:0] clr [PMD_NREG];
  logic [PMD_NREG-1:0] reen;

  genvar g;
  generate
    for (g = 0; g < PMD_NREG; g++) begin : g_reg
      pmd_ctrl_reg #(
        .MASK(MASKS[g])
      ) u_reg (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .wr_in(wr_en && hit[g]),
        .data_in(req.dat[7:0]),
        .value_out(regv[g]),
        .cleared_out(clr[g])
      );
      assign reen[g] = |clr[g];
      // Registers restart from reset values on re-enable; the window flags
      // the two cycles software must leave them alone.
      pmd_reen_hold #(
        .CYCLES(PMD_REEN_HOLD_CYC)
      ) u_hold (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .start_in(reen[g]), // [RL17] [RL18]
        .busy_out(reen_busy_out[g])
      );
    end
  endgenerate

  assign rsel = hit[0] ? regv[0] :
                hit[1] ? regv[1] :
                hit[2] ? regv[2] :
                hit[3] ? regv[3] :
                hit[4] ? regv[4] :
                hit[5] ? regv[5] :
                hit[6] ? regv[6] :
                hit[7] ? regv[7] : 8'h00;
  assign rdat_d = (access && mapped && !req.we) ? {24'h000000, rsel} : 32'h00000000;

  // Answer one cycle after the request, then drop for one cycle.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= access && mapped;
      err_q <= access && !mapped;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_err_out = err_q;
  assign wb_dat_out = rdat_q;

  // Memory controller state: settle window after re-enable.
  pmd_nvm_state_t nvm_q;
  pmd_nvm_state_t nvm_d;
  logic [7:0] settle_q;
  logic [7:0] settle_d;
  logic nvm_off;

  assign nvm_off = regv[0][PMD_B_NVM];

  always_comb begin
    nvm_d = nvm_q;
    settle_d = settle_q;
    case (nvm_q)
      PMD_NVM_ON: begin
        if (nvm_off) begin
          nvm_d = PMD_NVM_OFF;
        end
      end
      PMD_NVM_OFF: begin
        if (!nvm_off) begin
          nvm_d = PMD_NVM_SETTLE;
          settle_d = 8'(PMD_NVM_SETTLE_CYC - 1);
        end
      end
      PMD_NVM_SETTLE: begin
        if (nvm_off) begin
          nvm_d = PMD_NVM_OFF;
        end else if (settle_q == 8'h00) begin
          nvm_d = PMD_NVM_ON;
        end else begin
          settle_d = settle_q - 8'h01;
        end
      end
      default: begin
        nvm_d = PMD_NVM_ON;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      nvm_q <= PMD_NVM_ON;
      settle_q <= 8'h00;
    end else begin
      nvm_q <= nvm_d;
      settle_q <= settle_d;
    end
  end

  // Registered outputs.
  logic [4:0] c0_q;
  logic [2:0] mem_q;
  logic settle_out_q;
  pmd_periph_off_t off_q;
  pmd_periph_off_t off_d;

  assign off_d = '{
    timer_6_off: regv[1][6], // [RL8]
    timer_5_off: regv[1][5],
    timer_4_off: regv[1][4],
    timer_3_off: regv[1][3],
    timer_2_off: regv[1][2],
    timer_1_off: regv[1][1],
    timer_0_off: regv[1][0],
    num_osc_off: regv[2][7], // [RL9]
    dac_off: regv[3][6], // [RL10]
    adc_off: regv[3][5],
    comparator2_off: regv[3][2],
    comparator1_off: regv[3][1],
    zero_cross_off: regv[3][0],
    pwm_unit7_off: regv[4][6], // [RL11]
    pwm_unit6_off: regv[4][5],
    capcomp4_off: regv[4][3],
    capcomp3_off: regv[4][2],
    capcomp2_off: regv[4][1],
    capcomp1_off: regv[4][0],
    waveform_gen2_off: regv[5][6], // [RL12]
    waveform_gen1_off: regv[5][5],
    async_serial_off: regv[6][4], // [RL13]
    sync_serial_off: regv[6][0],
    signal_meas_timer_off: regv[7][5], // [RL14]
    logic_cell_4_off: regv[7][4],
    logic_cell_3_off: regv[7][3],
    logic_cell_2_off: regv[7][2],
    logic_cell_1_off: regv[7][1],
    signal_modulator_off: regv[7][0]
  };

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      c0_q <= 5'h00;
      mem_q <= 3'h0;
      settle_out_q <= 1'b0;
      off_q <= '0;
    end else begin
      c0_q[4] <= regv[0][PMD_B_CLKGATE]; // [RL1]
      c0_q[3] <= regv[0][PMD_B_FVR]; // [RL2]
      c0_q[2] <= nvm_off;
      c0_q[1] <= regv[0][PMD_B_CLKREF]; // [RL6]
      c0_q[0] <= regv[0][PMD_B_IOC]; // [RL7]
      mem_q[2] <= nvm_off; // [RL3]
      mem_q[1] <= nvm_off; // [RL3]
      mem_q[0] <= nvm_off; // [RL4]
      settle_out_q <= (nvm_d == PMD_NVM_SETTLE); // [RL5]
      off_q <= off_d; // [RL16]
    end
  end

  assign periph_clock_gate_out = c0_q[4];
  assign voltage_ref_off_out = c0_q[3];
  assign memory_ctrl_off_out = c0_q[2];
  assign ref_clock_out_off_out = c0_q[1];
  assign pin_change_off_out = c0_q[0];
  assign memory_access_block_out = mem_q[2];
  assign memory_ctrl_regs_wr_block_out = mem_q[1];
  assign indirect_pointer_zero_out = mem_q[0];
  assign memory_settling_out = settle_out_q;
  assign periph_off_out = off_q;

endmodule

// File: verif/pmd_bank_monitor.sv
// Purpose: Concurrent checks on the disable bank ports.
// Assumes: One clock domain; outputs follow a register write two edges later.
// Notes: Bound to every instance of the bank.
`timescale 1ns/1ps
module pmd_bank_monitor
  import pmd_pkg::*;
(
  // Clock, reset and bus
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [PMD_AW-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic wb_err_out,
  // Disable outputs
  input wire logic periph_clock_gate_out,
  input wire logic voltage_ref_off_out,
  input wire logic memory_ctrl_off_out,
  input wire logic ref_clock_out_off_out,
  input wire logic pin_change_off_out,
  input wire logic memory_access_block_out,
  input wire logic memory_ctrl_regs_wr_block_out,
  input wire logic indirect_pointer_zero_out,
  input wire logic memory_settling_out,
  input wire pmd_periph_off_t periph_off_out,
  input wire logic [PMD_NREG-1:0] reen_busy_out
);
  localparam logic [63:0] MASKS = {PMD_MASK7, PMD_MASK6, PMD_MASK5, PMD_MASK4,
                                   PMD_MASK3, PMD_MASK2, PMD_MASK1, PMD_MASK0};
  logic [63:0] obs;
  logic [63:0] po;
  logic [2:0] k;
  logic [7:0] mask_v;
  logic [7:0] exp_v;
  logic wr_map;
  logic [8:0] cnt_q;
  logic [8:0] cnt_d;

  // Outputs regrouped into the register layout so two checks cover all banks.
  assign po = 64'(periph_off_out);
  assign obs = {2'h0, po[5:0], 3'h0, po[7], 3'h0, po[6], 1'h0, po[9:8], 5'h0,
                1'h0, po[15:14], 1'h0, po[13:10], 1'h0, po[20:19], 2'h0, po[18:16],
                po[21], 7'h0, 1'h0, po[28:22], periph_clock_gate_out,
                voltage_ref_off_out, 3'h0, memory_ctrl_off_out,
                ref_clock_out_off_out, pin_change_off_out};
  assign k = 3'(wb_adr_in[13:2] - PMD_IDX_CTRL0);
  assign mask_v = MASKS[k*8 +: 8];
  assign exp_v = wb_dat_in[7:0] & mask_v;
  assign wr_map = wb_cyc_in & wb_stb_in & wb_we_in & wb_sel_in[0] & ~wb_ack_out
                  & ~wb_err_out & (wb_adr_in[13:2] >= PMD_IDX_CTRL0)
                  & (wb_adr_in[13:2] <= PMD_IDX_CTRL7);
  assign cnt_d = memory_settling_out ? cnt_q + 9'h1 : 9'h0;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) cnt_q <= 9'h0;
    else cnt_q <= cnt_d;
  end

  function automatic logic [7:0] pick(input logic [63:0] v, input logic [2:0] i);
    return v[i*8 +: 8];
  endfunction

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);

  ctrl0_map_a: assert property (
    wr_map && k == 3'h0 |-> ##2 pick(obs, 3'h0) == $past(exp_v, 2))
    else $error("control 0 outputs differ from written value");
  periph_map_a: assert property (
    wr_map && k != 3'h0 |-> ##2 pick(obs, $past(k, 2)) == $past(exp_v, 2))
    else $error("peripheral disables differ from written value");
  mem_block_a: assert property (
    memory_access_block_out == memory_ctrl_off_out
    && memory_ctrl_regs_wr_block_out == memory_ctrl_off_out)
    else $error("memory blocking does not follow memory disable");
  ptr_zero_a: assert property (
    indirect_pointer_zero_out == memory_ctrl_off_out)
    else $error("pointer zeroing does not follow memory disable");
  settle_start_a: assert property (
    $fell(memory_ctrl_off_out) |-> ##[0:1] memory_settling_out)
    else $error("settle window missing after memory enable");
  settle_len_a: assert property (
    $fell(memory_settling_out) && !memory_ctrl_off_out |-> cnt_q == 9'(PMD_NVM_SETTLE_CYC))
    else $error("settle window length wrong");
  reset_clear_a: assert property (
    $rose(resetn_in) |-> periph_off_out == '0 && obs == 64'h0 && reen_busy_out == '0)
    else $error("disable bits not clear after reset");
  unused_zero_a: assert property (
    wb_ack_out |-> (wb_dat_out[7:0] & ~$past(mask_v)) == 8'h0 && wb_dat_out[31:8] == '0)
    else $error("unused bits read nonzero");
  err_zero_a: assert property (
    wb_err_out |-> wb_dat_out == '0 && !wb_ack_out)
    else $error("refused access returned data");

  cover property (wr_map && k == 3'h0);
  cover property ($fell(memory_settling_out));
  cover property (wb_err_out);
endmodule

bind pmd_bank pmd_bank_monitor mon_u (.*);

// File: verif/pmd_bank_tb.sv
// Purpose: Self-checking bench for the disable bank.
// Assumes: Bus answers are sampled at the rising edge and the request is released there.
// Notes: Each scenario is its own task.
`timescale 1ns/1ps
module pmd_bank_tb;
  import pmd_pkg::*;
  localparam logic [63:0] MASKS = {PMD_MASK7, PMD_MASK6, PMD_MASK5, PMD_MASK4,
                                   PMD_MASK3, PMD_MASK2, PMD_MASK1, PMD_MASK0};
  logic mclk_in;
  logic resetn_in;
  logic wb_cyc_in;
  logic wb_stb_in;
  logic wb_we_in;
  logic [PMD_AW-1:0] wb_adr_in;
  logic [3:0] wb_sel_in;
  logic [31:0] wb_dat_in;
  logic [31:0] wb_dat_out;
  logic wb_ack_out;
  logic wb_err_out;
  logic periph_clock_gate_out;
  logic voltage_ref_off_out;
  logic memory_ctrl_off_out;
  logic ref_clock_out_off_out;
  logic pin_change_off_out;
  logic memory_access_block_out;
  logic memory_ctrl_regs_wr_block_out;
  logic indirect_pointer_zero_out;
  logic memory_settling_out;
  pmd_periph_off_t periph_off_out;
  logic [PMD_NREG-1:0] reen_busy_out;
  int error_cnt = 0;
  int tests_run = 0;

  pmd_bank dut_u (.*);

  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end

  task automatic finish_test();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Wait is bounded; a slave that never answers ends the run.
  task automatic xfer(input logic we, input logic [11:0] idx, input logic [3:0] sel,
                      input logic [7:0] wd, output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge mclk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= {idx, 2'h0};
    wb_sel_in <= sel;
    wb_dat_in <= {24'h0, wd};
    // The answer is judged at the rising edge, so the value that stood before it is seen.
    do begin
      @(posedge mclk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && wb_err_out !== 1'b1 && n < 20);
    if (wb_ack_out !== 1'b1 && wb_err_out !== 1'b1) begin
      chk("bus answer", 32'h0, 32'h1);
      finish_test();
    end else begin
      rd = wb_dat_out;
      er = wb_err_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
    end
  endtask

  task automatic t_reset_vals();
    logic [31:0] rd;
    logic er;
    for (int k = 0; k < 8; k++) begin
      xfer(1'b0, PMD_IDX_CTRL0 + 12'(k), 4'hf, 8'h0, rd, er);
      chk("reset value", rd, 32'h0);
    end
  endtask

  task automatic t_regs();
    logic [31:0] rd;
    logic er;
    for (int k = 0; k < 8; k++) begin
      xfer(1'b1, PMD_IDX_CTRL0 + 12'(k), 4'hf, 8'hff, rd, er);
      xfer(1'b0, PMD_IDX_CTRL0 + 12'(k), 4'hf, 8'h0, rd, er);
      chk("readback", rd, {24'h0, MASKS[k*8 +: 8]});
    end
    chk("periph off", 32'(periph_off_out), 32'h1fffffff);
    chk("ctrl0 outs", {periph_clock_gate_out, voltage_ref_off_out, ref_clock_out_off_out,
        pin_change_off_out}, 32'hf);
    for (int k = 0; k < 8; k++) begin
      xfer(1'b1, PMD_IDX_CTRL0 + 12'(k), 4'hf, 8'h00, rd, er);
    end
    // Outputs follow the last write at the same edge where the answer is seen.
    @(negedge mclk_in);
    chk("periph on", 32'(periph_off_out), 32'h0);
  endtask

  task automatic t_refuse();
    logic [31:0] rd;
    logic er;
    xfer(1'b1, PMD_IDX_CTRL3, 4'he, 8'hff, rd, er);
    xfer(1'b0, PMD_IDX_CTRL3, 4'hf, 8'h0, rd, er);
    chk("no byte enable", rd, 32'h0);
    xfer(1'b1, PMD_IDX_CTRL0 - 12'h1, 4'hf, 8'hff, rd, er);
    chk("unmapped wr err", 32'(er), 32'h1);
    xfer(1'b0, PMD_IDX_CTRL7 + 12'h1, 4'hf, 8'h0, rd, er);
    chk("unmapped rd", {rd[31:1], er}, 32'h1);
  endtask

  task automatic t_nvm();
    logic [31:0] rd;
    logic er;
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    xfer(1'b1, PMD_IDX_CTRL0, 4'hf, 8'h04, rd, er);
    @(negedge mclk_in);
    chk("mem gating", {memory_access_block_out, memory_ctrl_regs_wr_block_out,
        indirect_pointer_zero_out, memory_ctrl_off_out}, 32'hf);
    xfer(1'b1, PMD_IDX_CTRL0, 4'hf, 8'h00, rd, er);
    for (int i = 0; i < 400; i++) begin
      @(negedge mclk_in);
      if (reen_busy_out[0] === 1'b1) seen = 1'b1;
      if (memory_settling_out === 1'b1) n++;
      else if (n > 0) break;
    end
    chk("settle cycles", 32'(n), 32'(PMD_NVM_SETTLE_CYC));
    chk("reenable hold", 32'(seen), 32'h1);
    chk("mem free", 32'(indirect_pointer_zero_out), 32'h0);
  endtask

  task automatic t_reset_mid();
    logic [31:0] rd;
    logic er;
    xfer(1'b1, PMD_IDX_CTRL7, 4'hf, 8'hff, rd, er);
    xfer(1'b1, PMD_IDX_CTRL0, 4'hf, 8'h80, rd, er);
    @(posedge mclk_in);
    resetn_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    resetn_in <= 1'b1;
    xfer(1'b0, PMD_IDX_CTRL7, 4'hf, 8'h0, rd, er);
    chk("reg after reset", rd, 32'h0);
    chk("outs after reset", {periph_off_out, periph_clock_gate_out}, 32'h0);
  endtask

  initial begin
    resetn_in = 1'b0;
    wb_cyc_in = 1'b0;
    wb_stb_in = 1'b0;
    wb_we_in = 1'b0;
    wb_adr_in = '0;
    wb_sel_in = 4'h0;
    wb_dat_in = 32'h0;
    repeat (3) @(posedge mclk_in);
    resetn_in <= 1'b1;
    t_reset_vals();
    t_regs();
    t_refuse();
    t_nvm();
    t_reset_mid();
    finish_test();
  end
endmodule
